// >>> design/pcsc_pkg.sv
// Purpose: shared constants and types of the clock synthesis control block
// Assumes: 100 MHz system clock, 8-bit indexed sequencer register port
// Notes: the analog PLLs sit outside; this block only feeds them settings
package pcsc_pkg;
  // system clock
  localparam int CLK_PERIOD_NS = 10;
  // nominal settle time standing in for the variable load delay
  localparam int LOAD_DELAY_NS = 500;
  localparam int LOAD_DELAY_CYC = (LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 8;

  // sequencer indices
  localparam logic [7:0] IDX_FEAT_CLK_SEL = 8'h0B;
  localparam logic [7:0] IDX_MCLK_DIV = 8'h10;
  localparam logic [7:0] IDX_MCLK_MUL = 8'h11;
  localparam logic [7:0] IDX_ENH_DIV = 8'h12;
  localparam logic [7:0] IDX_ENH_MUL = 8'h13;
  localparam logic [7:0] IDX_TEST_CTL = 8'h14;
  localparam logic [7:0] IDX_LOAD_CTL = 8'h15;
  localparam logic [7:0] IDX_CNT_HIGH = 8'h16;
  localparam logic [7:0] IDX_CNT_LOW = 8'h17;
  localparam logic [7:0] IDX_SETB_DIV = 8'h21;
  localparam logic [7:0] IDX_SETB_MUL = 8'h22;
  localparam logic [7:0] IDX_SETC_DIV = 8'h23;
  localparam logic [7:0] IDX_SETC_MUL = 8'h24;

  // field positions
  localparam int MUL_LSB = 0;
  localparam int MUL_W = 7;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 5;
  localparam int MRANGE_LSB = 4;
  localparam int VRANGE_LSB = 5;
  localparam int RANGE_W = 3;
  localparam logic [2:0] MRANGE_MAX = 3'h3;
  localparam logic [2:0] VRANGE_MAX = 3'h4;
  localparam int LD_MCLK_BIT = 0;
  localparam int LD_PASSTHROUGH_CLOCK_IN_BIT = 1;
  localparam int LD_HALVE_BIT = 4;
  localparam int LD_IMM_BIT = 5;
  localparam int TST_GATE_BIT = 2;
  localparam int TST_SEL_BIT = 3;
  localparam int TST_CLR_BIT = 4;
  localparam int FEAT_VAFC_BIT = 1;
  localparam int CNT_W = 16;

  // clock-select codes of the misc output register
  localparam logic [1:0] CSEL_SET_B = 2'h0;
  localparam logic [1:0] CSEL_SET_C = 2'h1;
  localparam logic [1:0] CSEL_ENH = 2'h3;

  // settings driven to one analog PLL
  typedef struct packed {
    logic [7:0] m_plus2;
    logic [5:0] n_plus2;
    logic [4:0] post_div;
    logic [2:0] range;
  } pcsc_pll_cfg_type;

  // source of the pixel input clock
  typedef enum logic [1:0] {
    PCSC_SRC_VIDEO,
    PCSC_SRC_FEATURE,
    PCSC_SRC_PASSTHRU
  } pcsc_pix_src_type;

  // pixel input clock derivation controls
  typedef struct packed {
    pcsc_pix_src_type src;
    logic invert;
    logic [2:0] fraction;
    logic halve;
  } pcsc_pix_ctl_type;

  // control bits that live in other register files
  typedef struct packed {
    logic [1:0] clk_sel;
    logic pix_invert;
    logic [2:0] pix_fraction;
    logic border_clk_bit3;
  } pcsc_ext_ctl_type;
endpackage

// >>> design/pcsc_top.sv
// Purpose: sequencer clock registers, PLL parameter loading, pixel clock
//   selection and clock frequency measurement
// Assumes: measured clocks are slower than a quarter of clk_sys
// Notes: PLLs, oscillator and clock muxes themselves are analog/outside
module pcsc_top #(
  parameter logic [7:0] SETB_MUL_RST = 8'h00,
  parameter logic [7:0] SETB_DIV_RST = 8'h00,
  parameter logic [7:0] SETC_MUL_RST = 8'h00,
  parameter logic [7:0] SETC_DIV_RST = 8'h00,
  parameter logic [7:0] MCLK_MUL_RST = 8'h00,
  parameter logic [7:0] MCLK_DIV_RST = 8'h00,
  parameter int LOAD_DELAY = pcsc_pkg::LOAD_DELAY_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // indexed sequencer register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // bits from other register files
  input wire pcsc_pkg::pcsc_ext_ctl_type ext_ctl,
  // pins and measured clocks, asynchronous to clk_sys
  input wire logic passthrough_clock_enable,
  input wire logic mclk_meas,
  input wire logic video_clock_meas,
  // settings toward the analog PLLs and pixel clock mux
  output pcsc_pkg::pcsc_pll_cfg_type mclk_cfg,
  output pcsc_pkg::pcsc_pll_cfg_type video_clock_cfg,
  output pcsc_pkg::pcsc_pix_ctl_type pixel_input_clock_ctl
);

  // elaboration check: the delay counter must be able to reach its target
  if (LOAD_DELAY < 1 || LOAD_DELAY >= (1 << pcsc_pkg::DLY_W)) begin : g_bad_delay
    $error("pcsc_top: LOAD_DELAY out of range");
  end

  // register file storage
  logic [7:0] mclk_div_r, mclk_div_nxt; // mclk_divider_range
  logic [7:0] mclk_mul_r, mclk_mul_nxt; // mclk_multiplier
  logic [7:0] enh_div_r, enh_div_nxt; // video_clock_enh_divider_range
  logic [7:0] enh_mul_r, enh_mul_nxt; // video_clock_enh_multiplier
  logic [7:0] setb_div_r, setb_div_nxt; // video_clock_set_b_divider_range
  logic [7:0] setb_mul_r, setb_mul_nxt; // video_clock_set_b_multiplier
  logic [7:0] setc_div_r, setc_div_nxt; // video_clock_set_c_divider_range
  logic [7:0] setc_mul_r, setc_mul_nxt; // video_clock_set_c_multiplier
  logic [7:0] test_ctl_r, test_ctl_nxt; // clock_test_control
  logic [7:0] load_ctl_r, load_ctl_nxt; // clock_load_control
  logic [7:0] feat_sel_r, feat_sel_nxt; // feature_clock_select
  logic [7:0] rdata_r, rdata_nxt; // registered read data
  logic [7:0] low_shadow_r, low_shadow_nxt; // low byte caught at high read
  logic [pcsc_pkg::CNT_W-1:0] count_r; // measurement count

  // clamp a range code to its legal top
  function automatic logic [2:0] clamp_range(input logic [2:0] code, input logic [2:0] top);
    clamp_range = (code > top) ? top : code;
  endfunction

  // register writes; range fields saturate, reserved bits store zero
  always_comb begin
    mclk_div_nxt = mclk_div_r;
    mclk_mul_nxt = mclk_mul_r;
    enh_div_nxt = enh_div_r;
    enh_mul_nxt = enh_mul_r;
    setb_div_nxt = setb_div_r;
    setb_mul_nxt = setb_mul_r;
    setc_div_nxt = setc_div_r;
    setc_mul_nxt = setc_mul_r;
    test_ctl_nxt = test_ctl_r;
    load_ctl_nxt = load_ctl_r;
    feat_sel_nxt = feat_sel_r;
    if (reg_wr) begin
      case (reg_index)
        pcsc_pkg::IDX_MCLK_DIV: begin
          mclk_div_nxt = {1'b0,
            clamp_range(reg_wdata[pcsc_pkg::MRANGE_LSB +: pcsc_pkg::RANGE_W],
                        pcsc_pkg::MRANGE_MAX),
            reg_wdata[3:0]};
        end
        pcsc_pkg::IDX_MCLK_MUL: mclk_mul_nxt = {1'b0, reg_wdata[6:0]};
        pcsc_pkg::IDX_ENH_DIV: begin
          enh_div_nxt = {clamp_range(reg_wdata[pcsc_pkg::VRANGE_LSB +: pcsc_pkg::RANGE_W],
                                     pcsc_pkg::VRANGE_MAX),
                         reg_wdata[4:0]};
        end
        pcsc_pkg::IDX_ENH_MUL: enh_mul_nxt = {1'b0, reg_wdata[6:0]};
        pcsc_pkg::IDX_SETB_DIV: begin
          setb_div_nxt = {clamp_range(reg_wdata[pcsc_pkg::VRANGE_LSB +: pcsc_pkg::RANGE_W],
                                      pcsc_pkg::VRANGE_MAX),
                          reg_wdata[4:0]};
        end
        pcsc_pkg::IDX_SETB_MUL: setb_mul_nxt = {1'b0, reg_wdata[6:0]};
        pcsc_pkg::IDX_SETC_DIV: begin
          setc_div_nxt = {clamp_range(reg_wdata[pcsc_pkg::VRANGE_LSB +: pcsc_pkg::RANGE_W],
                                      pcsc_pkg::VRANGE_MAX),
                          reg_wdata[4:0]};
        end
        pcsc_pkg::IDX_SETC_MUL: setc_mul_nxt = {1'b0, reg_wdata[6:0]};
        pcsc_pkg::IDX_TEST_CTL: test_ctl_nxt = reg_wdata;
        pcsc_pkg::IDX_LOAD_CTL: load_ctl_nxt = reg_wdata;
        pcsc_pkg::IDX_FEAT_CLK_SEL: feat_sel_nxt = reg_wdata;
        default: ; // count registers are read only; others ignored
      endcase
    end
  end

  // read path: one cycle latency; the high-byte read freezes the low byte
  // so a high-then-low pair always belongs to one count
  always_comb begin
    rdata_nxt = rdata_r;
    low_shadow_nxt = low_shadow_r;
    if (reg_rd) begin
      case (reg_index)
        pcsc_pkg::IDX_MCLK_DIV: rdata_nxt = mclk_div_r;
        pcsc_pkg::IDX_MCLK_MUL: rdata_nxt = mclk_mul_r;
        pcsc_pkg::IDX_ENH_DIV: rdata_nxt = enh_div_r;
        pcsc_pkg::IDX_ENH_MUL: rdata_nxt = enh_mul_r;
        pcsc_pkg::IDX_SETB_DIV: rdata_nxt = setb_div_r;
        pcsc_pkg::IDX_SETB_MUL: rdata_nxt = setb_mul_r;
        pcsc_pkg::IDX_SETC_DIV: rdata_nxt = setc_div_r;
        pcsc_pkg::IDX_SETC_MUL: rdata_nxt = setc_mul_r;
        pcsc_pkg::IDX_TEST_CTL: rdata_nxt = test_ctl_r;
        pcsc_pkg::IDX_LOAD_CTL: rdata_nxt = load_ctl_r;
        pcsc_pkg::IDX_FEAT_CLK_SEL: rdata_nxt = feat_sel_r;
        pcsc_pkg::IDX_CNT_HIGH: begin
          rdata_nxt = count_r[15:8];
          low_shadow_nxt = count_r[7:0];
        end
        pcsc_pkg::IDX_CNT_LOW: rdata_nxt = low_shadow_r;
        default: rdata_nxt = 8'h00; // unmapped index reads zero
      endcase
    end
  end

  // register file flops; power-on values of the VGA pairs are parameters
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mclk_div_r <= MCLK_DIV_RST;
      mclk_mul_r <= MCLK_MUL_RST;
      enh_div_r <= 8'h00; // undefined at power-on, zero here
      enh_mul_r <= 8'h00;
      setb_div_r <= SETB_DIV_RST;
      setb_mul_r <= SETB_MUL_RST;
      setc_div_r <= SETC_DIV_RST;
      setc_mul_r <= SETC_MUL_RST;
      test_ctl_r <= 8'h00;
      load_ctl_r <= 8'h00;
      feat_sel_r <= 8'h00;
      rdata_r <= 8'h00;
      low_shadow_r <= 8'h00;
    end else begin
      mclk_div_r <= mclk_div_nxt;
      mclk_mul_r <= mclk_mul_nxt;
      enh_div_r <= enh_div_nxt;
      enh_mul_r <= enh_mul_nxt;
      setb_div_r <= setb_div_nxt;
      setb_mul_r <= setb_mul_nxt;
      setc_div_r <= setc_div_nxt;
      setc_mul_r <= setc_mul_nxt;
      test_ctl_r <= test_ctl_nxt;
      load_ctl_r <= load_ctl_nxt;
      feat_sel_r <= feat_sel_nxt;
      rdata_r <= rdata_nxt;
      low_shadow_r <= low_shadow_nxt;
    end
  end
  assign reg_rdata = rdata_r;
  // build PLL settings from a multiplier and divider/range pair
  function automatic pcsc_pkg::pcsc_pll_cfg_type make_cfg(input logic [6:0] mul,
                                                         input logic [4:0] div,
                                                         input logic [2:0] range);
    make_cfg.m_plus2 = {1'b0, mul} + 8'h02;
    make_cfg.n_plus2 = {1'b0, div} + 6'h02;
    make_cfg.post_div = 5'h01 << range;
    make_cfg.range = range;
  endfunction

  // candidate settings: selected video pair and memory pair
  pcsc_pkg::pcsc_pll_cfg_type vsel_cfg; // video pair picked by clk_sel
  pcsc_pkg::pcsc_pll_cfg_type mreg_cfg; // memory pair as programmed
  logic vsel_valid; // select code 10 names no pair; keep what runs

  always_comb begin
    mreg_cfg = make_cfg(mclk_mul_r[6:0], mclk_div_r[4:0],
                        mclk_div_r[pcsc_pkg::MRANGE_LSB +: pcsc_pkg::RANGE_W]);
    vsel_valid = 1'b1;
    case (ext_ctl.clk_sel)
      pcsc_pkg::CSEL_SET_B: begin
        vsel_cfg = make_cfg(setb_mul_r[6:0], setb_div_r[4:0],
                            setb_div_r[pcsc_pkg::VRANGE_LSB +: pcsc_pkg::RANGE_W]);
      end
      pcsc_pkg::CSEL_SET_C: begin
        vsel_cfg = make_cfg(setc_mul_r[6:0], setc_div_r[4:0],
                            setc_div_r[pcsc_pkg::VRANGE_LSB +: pcsc_pkg::RANGE_W]);
      end
      pcsc_pkg::CSEL_ENH: begin
        vsel_cfg = make_cfg(enh_mul_r[6:0], enh_div_r[4:0],
                            enh_div_r[pcsc_pkg::VRANGE_LSB +: pcsc_pkg::RANGE_W]);
      end
      default: begin
        vsel_cfg = video_clock_cfg;
        vsel_valid = 1'b0;
      end
    endcase
  end

  // loading of active settings; index 0 memory, 1 video
  logic [pcsc_pkg::DLY_W-1:0] dly_r [2];
  logic [pcsc_pkg::DLY_W-1:0] dly_nxt [2];
  logic imm_prev_r, imm_prev_nxt; // last seen immediate-load bit
  pcsc_pkg::pcsc_pll_cfg_type mact_r, mact_nxt;
  pcsc_pkg::pcsc_pll_cfg_type vact_r, vact_nxt;
  logic imm_fall; // immediate bit went 1 -> 0
  logic [1:0] armed; // delayed loading requested per PLL
  logic [1:0] fire; // delayed load due this cycle
  // a stuck-high load bit reloads once per delay period; harmless for the
  // video pair, which is meant to be left set, and why memory must clear it
  always_comb begin
    imm_fall = imm_prev_r & ~load_ctl_r[pcsc_pkg::LD_IMM_BIT];
    imm_prev_nxt = load_ctl_r[pcsc_pkg::LD_IMM_BIT];
    armed[0] = load_ctl_r[pcsc_pkg::LD_MCLK_BIT] & ~load_ctl_r[pcsc_pkg::LD_IMM_BIT];
    armed[1] = load_ctl_r[pcsc_pkg::LD_PASSTHROUGH_CLOCK_IN_BIT] & ~load_ctl_r[pcsc_pkg::LD_IMM_BIT];
    for (int i = 0; i < 2; i++) begin
      fire[i] = armed[i] && (dly_r[i] == LOAD_DELAY[pcsc_pkg::DLY_W-1:0]);
      if (!armed[i] || fire[i]) begin
        dly_nxt[i] = '0;
      end else begin
        dly_nxt[i] = dly_r[i] + 1'b1;
      end
    end
    mact_nxt = mact_r;
    vact_nxt = vact_r;
    if (imm_fall || fire[0]) begin
      mact_nxt = mreg_cfg;
    end
    if ((imm_fall || fire[1]) && vsel_valid) begin
      vact_nxt = vsel_cfg;
    end
  end

  // active settings come up as the power-on pairs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dly_r[0] <= '0;
      dly_r[1] <= '0;
      imm_prev_r <= 1'b0;
      mact_r <= make_cfg(MCLK_MUL_RST[6:0], MCLK_DIV_RST[4:0],
                         MCLK_DIV_RST[pcsc_pkg::MRANGE_LSB +: pcsc_pkg::RANGE_W]);
      vact_r <= make_cfg(SETB_MUL_RST[6:0], SETB_DIV_RST[4:0],
                         SETB_DIV_RST[pcsc_pkg::VRANGE_LSB +: pcsc_pkg::RANGE_W]);
    end else begin
      dly_r[0] <= dly_nxt[0];
      dly_r[1] <= dly_nxt[1];
      imm_prev_r <= imm_prev_nxt;
      mact_r <= mact_nxt;
      vact_r <= vact_nxt;
    end
  end
  assign mclk_cfg = mact_r;
  assign video_clock_cfg = vact_r;

  // three-stage samplers for asynchronous inputs: [0] enable pin,
  // [1] memory clock, [2] video clock
  logic [2:0] sync1_r, sync2_r, sync3_r, filt_r;
  logic [2:0] filt_nxt;

  // a change counts only when stages two and three agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      filt_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : filt_r[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
      filt_r <= 3'h0;
    end else begin
      sync1_r <= {video_clock_meas, mclk_meas, passthrough_clock_enable};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r <= filt_nxt;
    end
  end

  // pixel input clock derivation; with border_clk_bit3 clear, passthrough wins
  // over the feature connector since its enable is an explicit request from the far side
  pcsc_pkg::pcsc_pix_ctl_type pix_nxt, pix_r;

  always_comb begin
    pix_nxt.invert = ext_ctl.pix_invert;
    pix_nxt.fraction = ext_ctl.pix_fraction;
    pix_nxt.halve = load_ctl_r[pcsc_pkg::LD_HALVE_BIT] & ~ext_ctl.border_clk_bit3;
    if (filt_r[0] && !ext_ctl.border_clk_bit3) begin
      pix_nxt.src = pcsc_pkg::PCSC_SRC_PASSTHRU;
    end else if (feat_sel_r[pcsc_pkg::FEAT_VAFC_BIT]) begin
      pix_nxt.src = pcsc_pkg::PCSC_SRC_FEATURE;
    end else begin
      pix_nxt.src = pcsc_pkg::PCSC_SRC_VIDEO;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pix_r <= '{src: pcsc_pkg::PCSC_SRC_VIDEO, invert: 1'b0, fraction: 3'h0, halve: 1'b0};
    end else begin
      pix_r <= pix_nxt;
    end
  end
  assign pixel_input_clock_ctl = pix_r;

  // frequency measurement: rising edges of the chosen clock while gated
  logic [pcsc_pkg::CNT_W-1:0] count_nxt;
  logic clr_prev_r, clr_prev_nxt; // last seen clear bit
  logic sel_edge; // filtered rising edge of the measured clock

  always_comb begin
    clr_prev_nxt = test_ctl_r[pcsc_pkg::TST_CLR_BIT];
    if (test_ctl_r[pcsc_pkg::TST_SEL_BIT]) begin
      sel_edge = filt_nxt[2] & ~filt_r[2];
    end else begin
      sel_edge = filt_nxt[1] & ~filt_r[1];
    end
    if (clr_prev_r != test_ctl_r[pcsc_pkg::TST_CLR_BIT]) begin
      count_nxt = '0;
    end else if (test_ctl_r[pcsc_pkg::TST_GATE_BIT] && sel_edge) begin
      count_nxt = count_r + 1'b1;
    end else begin
      count_nxt = count_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count_r <= '0;
      clr_prev_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      clr_prev_r <= clr_prev_nxt;
    end
  end
endmodule

// >>> testbench/pcsc_top_chk.sv
// Purpose: port checks of the clock synthesis control block
// Assumes: one clk_sys domain, synchronous active-low reset
// Notes: bound into pcsc_top; watches its ports only
module pcsc_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // controls and settings
  input wire pcsc_pkg::pcsc_ext_ctl_type ext_ctl,
  input wire pcsc_pkg::pcsc_pll_cfg_type mclk_cfg,
  input wire pcsc_pkg::pcsc_pll_cfg_type video_clock_cfg,
  input wire pcsc_pkg::pcsc_pix_ctl_type pixel_input_clock_ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic [6:0] mmul_r; // shadow of the memory multiplier
  logic [6:0] mmul_nxt;
  logic imm_r; // shadow of the immediate-load bit
  logic imm_nxt;
  logic ld_wr; // write to the load control register
  // shadows follow writes so an immediate load can be predicted
  always_comb begin
    ld_wr = reg_wr && reg_index == pcsc_pkg::IDX_LOAD_CTL;
    mmul_nxt = mmul_r;
    imm_nxt = imm_r;
    if (reg_wr && reg_index == pcsc_pkg::IDX_MCLK_MUL) begin
      mmul_nxt = reg_wdata[6:0];
    end
    if (ld_wr) begin
      imm_nxt = reg_wdata[5];
    end
  end
  // zero reset, as the design's default parameters
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mmul_r <= 7'h00;
      imm_r <= 1'b0;
    end else begin
      mmul_r <= mmul_nxt;
      imm_r <= imm_nxt;
    end
  end
  a_rdata_holds:
    assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  a_mul_top_bit:
    assert property (reg_rd && reg_index inside {8'h11, 8'h13, 8'h22, 8'h24}
      |=> !reg_rdata[7]) else $error("multiplier bit 7 set");
  a_mrange_max:
    assert property (reg_rd && reg_index == pcsc_pkg::IDX_MCLK_DIV
      |=> !reg_rdata[7] && reg_rdata[6:4] <= 3'h3) else $error("memory range too big");
  a_vrange_max:
    assert property (reg_rd && reg_index inside {8'h12, 8'h21, 8'h23}
      |=> reg_rdata[7:5] <= 3'h4) else $error("video range too big");
  a_vpost_div:
    assert property (video_clock_cfg.post_div == 5'h01 << video_clock_cfg.range
      && video_clock_cfg.range <= 3'h4) else $error("video post divider wrong");
  a_mpost_div:
    assert property (mclk_cfg.post_div == 5'h01 << mclk_cfg.range
      && mclk_cfg.range <= 3'h3) else $error("memory post divider wrong");
  a_imm_load:
    assert property (ld_wr && imm_r && !reg_wdata[5]
      |-> ##3 mclk_cfg.m_plus2 == {1'b0, mmul_r} + 8'h02) else $error("no immediate load");
  a_border_block:
    assert property (ext_ctl.border_clk_bit3 ##1 ext_ctl.border_clk_bit3
      |-> !pixel_input_clock_ctl.halve
      && pixel_input_clock_ctl.src != pcsc_pkg::PCSC_SRC_PASSTHRU) else $error("border ignored");
  a_invert_copy:
    assert property ($past(rst_b) |-> pixel_input_clock_ctl.invert == $past(ext_ctl.pix_invert)
      && pixel_input_clock_ctl.fraction == $past(ext_ctl.pix_fraction)) else $error("pix ctl");
  c_imm_load: cover property (ld_wr && imm_r && !reg_wdata[5]);
  c_gate: cover property (reg_wr && reg_index == pcsc_pkg::IDX_TEST_CTL && reg_wdata[2]);
  c_halve: cover property (pixel_input_clock_ctl.halve);
endmodule

bind pcsc_top pcsc_chk u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_ctl(ext_ctl),
  .mclk_cfg(mclk_cfg), .video_clock_cfg(video_clock_cfg),
  .pixel_input_clock_ctl(pixel_input_clock_ctl)
);

// >>> testbench/tb_pll_clock_synth_control.sv
// Purpose: self-checking bench of the clock synthesis control block
// Assumes: load delay shortened to LD cycles
// Notes: integer model of the registers; inputs change at the falling edge
module tb_pll_clock_synth_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LD = 3; // short load delay keeps the run brief
  logic clk_sys;
  logic rst_b;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_index;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  pcsc_pkg::pcsc_ext_ctl_type ext_ctl;
  logic pte; // passthrough clock enable pin
  logic mclk_meas;
  logic passthrough_clock_in_meas;
  pcsc_pkg::pcsc_pll_cfg_type mclk_cfg;
  pcsc_pkg::pcsc_pll_cfg_type vcfg;
  pcsc_pkg::pcsc_pix_ctl_type pix;
  int mismatches;
  int total_checks;
  logic [31:0] seed; // lfsr state
  int mdl[int]; // register model by index
  int ix[8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h21, 8'h22, 8'h23, 8'h24};
  int all[$] = {8'h0B, 8'h14, 8'h15, 8'h16, 8'h17, 8'h30};
  int dvi[4] = '{8'h21, 8'h23, 8'h21, 8'h12}; // divider index per select code
  logic [21:0] ev; // expected video setting
  logic [21:0] em; // expected memory setting
  logic [7:0] rb; // last read data
  int r;
  int n;
  pcsc_top #(.LOAD_DELAY(LD)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_index(reg_index), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_ctl(ext_ctl),
    .passthrough_clock_enable(pte), .mclk_meas(mclk_meas), .video_clock_meas(passthrough_clock_in_meas),
    .mclk_cfg(mclk_cfg), .video_clock_cfg(vcfg), .pixel_input_clock_ctl(pix));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // new byte from the lfsr
  function automatic int rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[7:0]);
  endfunction
  // stored value: reserved bits zero, range saturated
  function automatic int fix(input int i, input int d);
    int rg;
    if (i inside {8'h11, 8'h13, 8'h22, 8'h24}) return d & 8'h7F;
    rg = (i == 8'h10) ? (d >> 4) & 7 : d >> 5;
    if (i == 8'h10) return ((rg > 3 ? 3 : rg) << 4) | (d & 8'h1F);
    return ((rg > 4 ? 4 : rg) << 5) | (d & 8'h1F);
  endfunction
  // expected PLL setting from stored divider and multiplier
  function automatic logic [21:0] pll(input int dv, input int ml, input int vid);
    int rg;
    rg = vid ? dv >> 5 : (dv >> 4) & 7;
    return {8'(ml + 2), 6'(dv % 32 + 2), 5'(1 << rg), 3'(rg)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe, released at the next falling edge
  task automatic wr(input int i, input int d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_index = 8'(i);
    reg_wdata = 8'(d);
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  // write and update the model
  task automatic wm(input int i, input int d);
    wr(i, d);
    mdl[i] = fix(i, d);
  endtask
  // data is ready one edge after the read strobe
  task automatic rd(input int i);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_index = 8'(i);
    @(negedge clk_sys);
    reg_rd = 1'b0;
    rb = reg_rdata;
  endtask
  // n rising edges of one measured clock, four cycles a phase
  task automatic tick(input int cnt, input int vid);
    repeat (cnt) begin
      repeat (4) @(negedge clk_sys);
      {passthrough_clock_in_meas, mclk_meas} = vid ? 2'h2 : 2'h1;
      repeat (4) @(negedge clk_sys);
      {passthrough_clock_in_meas, mclk_meas} = 2'h0;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // guard against a hang
  initial begin
    repeat (100000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end
  initial begin
    {reg_wr, reg_rd, reg_index, reg_wdata, pte, mclk_meas, passthrough_clock_in_meas} = '0;
    ext_ctl = '0;
    mismatches = 0;
    total_checks = 0;
    seed = 32'h00010143; // starts at 65859
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    // reset values, unmapped index included
    foreach (ix[k]) all.push_back(ix[k]);
    foreach (all[k]) begin
      rd(all[k]);
      chk("reset", rb, 0);
    end
    // all-ones pass hits saturation, then random data; count high byte ignores writes
    for (int p = 0; p < 2; p++) begin
      foreach (ix[k]) wm(ix[k], p ? rnd() : 8'hFF);
      wr(8'h16, 8'hFF);
      foreach (ix[k]) begin
        rd(ix[k]);
        chk("reg", rb, mdl[ix[k]]);
      end
      rd(8'h16);
      chk("cnt_hi", rb, 0);
    end
    // immediate load under each select code; code 10 loads no video setting
    ev = pll(0, 0, 1);
    for (int s = 0; s < 4; s++) begin
      ext_ctl.clk_sel = 2'(s);
      foreach (ix[k]) wm(ix[k], rnd());
      wr(8'h15, 8'h20);
      wr(8'h15, 8'h00);
      repeat (3) @(negedge clk_sys);
      ev = (s == 2) ? ev : pll(mdl[dvi[s]], mdl[dvi[s] + 1], 1);
      em = pll(mdl[8'h10], mdl[8'h11], 0);
      chk("video", vcfg, ev);
      chk("mem", mclk_cfg, em);
    end
    // delayed loads, video first with a host-style code pair, then memory
    wm(8'h12, 8'h34);
    wm(8'h13, 8'h56);
    wr(8'h15, 8'h02);
    chk("video", vcfg, ev);
    repeat (LD + 3) @(negedge clk_sys);
    ev = pll(mdl[8'h12], mdl[8'h13], 1);
    chk("video", vcfg, ev);
    wm(8'h10, rnd());
    wm(8'h11, rnd());
    wr(8'h15, 8'h03);
    chk("mem", mclk_cfg, em);
    repeat (LD + 3) @(negedge clk_sys);
    em = pll(mdl[8'h10], mdl[8'h11], 0);
    chk("mem", mclk_cfg, em);
    wr(8'h15, 8'h00);
    // pixel input clock source, inversion, fraction and halving
    repeat (16) begin
      r = rnd();
      wr(8'h0B, (r & 4) >> 1);
      wr(8'h15, (r & 8) << 1);
      pte = r[0];
      ext_ctl.border_clk_bit3 = r[1];
      ext_ctl.pix_invert = r[4];
      ext_ctl.pix_fraction = r[7:5];
      repeat (6) @(negedge clk_sys);
      n = (r[0] && !r[1]) ? 2 : r[2];
      chk("pix", pix, {2'(n), r[4], r[7:5], r[3] & !r[1]});
    end
    // measurement of memory then video clock; other clock runs before the gate
    for (int v = 0; v < 2; v++) begin
      n = 256 + rnd();
      wr(8'h14, 8'h10 | (v << 3));
      tick(5, 1 - v);
      wr(8'h14, 8'h14 | (v << 3));
      tick(n, v);
      repeat (8) @(negedge clk_sys);
      wr(8'h14, 8'h10 | (v << 3));
      tick(3, v);
      rd(8'h16);
      chk("cnt_hi", rb, n >> 8);
      rd(8'h17);
      chk("cnt_lo", rb, n & 8'hFF);
      wr(8'h14, v << 3);
      rd(8'h16);
      chk("cnt_hi", rb, 0);
      rd(8'h17);
      chk("cnt_lo", rb, 0);
    end
    end_of_test();
  end
endmodule
